// ===== rtl/nvhc_map.vh
`ifndef NVHC_MAP_VH
`define NVHC_MAP_VH
`define NVHC_CLK_PS 8000
`define NVHC_T_RC_PS 25000
`define NVHC_T_CW_PS 20000
`define NVHC_T_SD_PS 10000
`define NVHC_T_DOE_PS 12000
`define NVHC_T_HZ_PS 10000
`define NVHC_T_PHSB_PS 15000
`define NVHC_T_DHSB_PS 25000
`define NVHC_T_SS_NS 100000
`define NVHC_T_RTCP_NS 350000
`define NVHC_T_HRECALL_NS 20000000
`define NVHC_CYC_UP(ps) (((ps) + `NVHC_CLK_PS - 1) / `NVHC_CLK_PS)
`define NVHC_RC_CYC `NVHC_CYC_UP(`NVHC_T_RC_PS)
`define NVHC_CW_CYC `NVHC_CYC_UP(`NVHC_T_CW_PS)
`define NVHC_ACC_CYC `NVHC_CYC_UP(`NVHC_T_RC_PS)
`define NVHC_HZ_CYC `NVHC_CYC_UP(`NVHC_T_HZ_PS)
`define NVHC_PHSB_CYC `NVHC_CYC_UP(`NVHC_T_PHSB_PS)
`define NVHC_DHSB_CYC `NVHC_CYC_UP(`NVHC_T_DHSB_PS)
`define NVHC_SS_CYC (`NVHC_T_SS_NS / (`NVHC_CLK_PS / 1000))
`define NVHC_RTCP_CYC (`NVHC_T_RTCP_NS / (`NVHC_CLK_PS / 1000))
`define NVHC_HREC_CYC (`NVHC_T_HRECALL_NS / (`NVHC_CLK_PS / 1000))
`define NVHC_OP_READ 2'h0
`define NVHC_OP_WRITE 2'h1
`define NVHC_OP_SAVE 2'h2
`define NVHC_OP_WAIT 2'h3
`endif

// ===== rtl/nvhc_timer.v
`include "nvhc_map.vh"
module nvhc_timer (
  input wire mclk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire load_i,
  input wire [31:0] count_i,
  output wire done_o
);
  reg [31:0] cnt_reg;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 32'h00000000;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_reg <= count_i;
      end else if (cnt_reg != 32'h00000000) begin
        cnt_reg <= cnt_reg - 32'h00000001;
      end
    end
  end
  assign done_o = (cnt_reg == 32'h00000000);
endmodule

// ===== rtl/nvhc_host.v
`include "nvhc_map.vh"
module nvhc_host #(
  parameter [31:0] SS_CYC = `NVHC_SS_CYC,
  parameter [31:0] RTCP_CYC = `NVHC_RTCP_CYC,
  parameter [31:0] HREC_CYC = `NVHC_HREC_CYC
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire en_i,
  input wire req_valid_i,
  input wire [1:0] req_op_i,
  input wire [14:0] req_addr_i,
  input wire [7:0] req_wdata_i,
  input wire req_cmd_step_i,
  input wire req_last_step_i,
  input wire req_clk_upd_i,
  output wire req_ready_o,
  output wire rsp_valid_o,
  output reg [7:0] rsp_rdata_o,
  output reg rsp_untrusted_o,
  output reg [14:0] mem_addr_o,
  output reg [7:0] mem_dq_o,
  output reg mem_dq_oe_o,
  input wire [7:0] mem_dq_i,
  output reg mem_ce_n_o,
  output reg mem_we_n_o,
  output reg mem_oe_n_o,
  output reg hw_save_busy_n_o,
  output reg hw_save_busy_n_oe_o,
  input wire hw_save_busy_n_i,
  input wire supply_ok_i,
  output wire busy_o
);
  localparam [5:0] S_BOOT = 6'h01;
  localparam [5:0] S_IDLE = 6'h02;
  localparam [5:0] S_RD = 6'h04;
  localparam [5:0] S_WR = 6'h08;
  localparam [5:0] S_SAVE = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;
  reg [5:0] st_reg;
  reg [5:0] st_next;
  reg [7:0] cyc_reg;
  reg rsp_reg;
  reg last_reg;
  reg [2:0] step_reg;
  reg [2:0] step_next;
  reg last_next;
  reg ce_n_next;
  reg we_n_next;
  reg oe_n_next;
  reg dq_oe_next;
  reg hsb_oe_next;
  reg tload;
  reg [31:0] tcount;
  wire tdone;

  nvhc_timer u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(en_i),
    .load_i(tload),
    .count_i(tcount),
    .done_o(tdone)
  );

  function [7:0] cyc8;
    input integer n;
    begin
      cyc8 = n[7:0];
    end
  endfunction

  // Read request that belongs to a software command sequence
  function cmd_read;
    input [1:0] op;
    input step;
    begin
      cmd_read = (op == `NVHC_OP_READ) && step;
    end
  endfunction

  // Device busy: save/restore running or supply low
  wire dev_busy = !hw_save_busy_n_i || !supply_ok_i;
  assign req_ready_o = (st_reg == S_IDLE) && !dev_busy && tdone;
  assign rsp_valid_o = rsp_reg;
  assign busy_o = !req_ready_o;
  wire take = (st_reg == S_IDLE) && req_valid_i && req_ready_o;

  always @* begin
    st_next = st_reg;
    tload = 1'b0;
    tcount = 32'h00000000;
    step_next = step_reg;
    last_next = last_reg;
    ce_n_next = 1'b1;
    we_n_next = 1'b1;
    oe_n_next = 1'b1;
    dq_oe_next = 1'b0;
    hsb_oe_next = 1'b0;
    case (st_reg)
      S_BOOT: begin
        if (supply_ok_i) begin
          tload = 1'b1;
          tcount = HREC_CYC;
          st_next = S_WAIT;
        end
      end
      S_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          case (req_op_i)
            `NVHC_OP_READ: st_next = S_RD;
            `NVHC_OP_WRITE: st_next = S_WR;
            `NVHC_OP_SAVE: st_next = S_SAVE;
            default: begin
              tload = 1'b1;
              tcount = req_clk_upd_i ? RTCP_CYC : SS_CYC;
              st_next = S_WAIT;
            end
          endcase
        end
      end
      S_RD: begin
        if (cyc_reg == cyc8(`NVHC_RC_CYC) - 8'h01) begin
          if (last_reg) begin
            tload = 1'b1;
            tcount = SS_CYC;
            st_next = S_WAIT;
          end else begin
            st_next = S_IDLE;
          end
        end
      end
      S_WR: begin
        if (cyc_reg == cyc8(`NVHC_RC_CYC) - 8'h01) begin
          st_next = S_IDLE;
        end
      end
      S_SAVE: begin
        if (cyc_reg == cyc8(`NVHC_PHSB_CYC + `NVHC_DHSB_CYC) - 8'h01) begin
          st_next = S_WAIT;
        end
      end
      S_WAIT: begin
        if (tdone && hw_save_busy_n_i && supply_ok_i) begin
          st_next = S_IDLE;
        end
      end
      default: st_next = S_BOOT;
    endcase
    // Supply below threshold: drop everything and wait for restore
    if (!supply_ok_i) begin
      st_next = S_BOOT;
    end
    // Six back-to-back command reads, counted at the take edge
    if (take) begin
      if (cmd_read(req_op_i, req_cmd_step_i)) begin
        step_next = (step_reg == 3'h5) ? 3'h0 : step_reg + 3'h1;
      end else begin
        step_next = 3'h0;
      end
      // Last flag only honoured on the sixth step of an unbroken run
      last_next = cmd_read(req_op_i, req_cmd_step_i) && req_last_step_i &&
                  (step_reg == 3'h5);
    end
    // Read: select and gate low, write strobe stays high
    if (st_next == S_RD) begin
      ce_n_next = 1'b0;
      oe_n_next = 1'b0;
    end
    // Write strobe falls with select so outputs stay off
    if (st_next == S_WR) begin
      ce_n_next = 1'b0;
      we_n_next = (st_reg == S_WR) && (cyc_reg >= cyc8(`NVHC_CW_CYC) - 8'h01);
      dq_oe_next = 1'b1;
    end
    // Save pin only pulled during a save request, never in an access
    if (st_next == S_SAVE) begin
      hsb_oe_next = (st_reg != S_SAVE) ||
                    (cyc_reg < cyc8(`NVHC_PHSB_CYC) - 8'h01);
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= S_BOOT;
      cyc_reg <= 8'h00;
      rsp_reg <= 1'b0;
      last_reg <= 1'b0;
      step_reg <= 3'h0;
      rsp_rdata_o <= 8'h00;
      rsp_untrusted_o <= 1'b0;
      mem_addr_o <= 15'h0000;
      mem_dq_o <= 8'h00;
      mem_dq_oe_o <= 1'b0;
      mem_ce_n_o <= 1'b1;
      mem_we_n_o <= 1'b1;
      mem_oe_n_o <= 1'b1;
      hw_save_busy_n_o <= 1'b1;
      hw_save_busy_n_oe_o <= 1'b0;
    end else if (en_i) begin
      st_reg <= st_next;
      step_reg <= step_next;
      last_reg <= last_next;
      rsp_reg <= 1'b0;
      cyc_reg <= (st_next == st_reg) ? cyc_reg + 8'h01 : 8'h00;
      if (take) begin
        mem_addr_o <= req_addr_i;
        mem_dq_o <= req_wdata_i;
      end
      mem_ce_n_o <= ce_n_next;
      mem_oe_n_o <= oe_n_next;
      mem_we_n_o <= we_n_next;
      mem_dq_oe_o <= dq_oe_next;
      // Open-drain save pin: level stays low, the enable does the pulling
      hw_save_busy_n_o <= 1'b0;
      hw_save_busy_n_oe_o <= hsb_oe_next;
      if (st_reg == S_RD && st_next != S_RD) begin
        rsp_rdata_o <= mem_dq_i;
        rsp_untrusted_o <= last_reg;
        rsp_reg <= 1'b1;
      end
      if (st_reg == S_WR && st_next != S_WR) begin
        rsp_untrusted_o <= 1'b0;
        rsp_reg <= 1'b1;
      end
    end
  end
endmodule

// ===== testbench/nvhc_host_chk.sv
module nvhc_host_chk (
  input wire mclk_i,
  input wire rst_n_i,
  input wire req_valid_i,
  input wire [1:0] req_op_i,
  input wire req_ready_o,
  input wire rsp_valid_o,
  input wire rsp_untrusted_o,
  input wire mem_ce_n_o,
  input wire mem_we_n_o,
  input wire mem_oe_n_o,
  input wire hw_save_busy_n_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd; !mem_ce_n_o && !mem_oe_n_o |-> mem_we_n_o; endproperty
  a_rd: assert property (p_rd) else $error("write low in read");
  property p_pin; !mem_ce_n_o |-> !hw_save_busy_n_oe_o; endproperty
  a_pin: assert property (p_pin) else $error("pin pulled in access");
  property p_pw; $rose(hw_save_busy_n_oe_o) |=> hw_save_busy_n_oe_o; endproperty
  a_pw: assert property (p_pw) else $error("save pulse short");
  property p_end; rsp_valid_o |-> mem_ce_n_o && mem_oe_n_o; endproperty
  a_end: assert property (p_end) else $error("read not closed");
  property p_six; rsp_valid_o && rsp_untrusted_o |-> $past(mem_we_n_o); endproperty
  a_six: assert property (p_six) else $error("write low in step");
  c_rd: cover property (req_valid_i && req_ready_o && req_op_i == 2'h0 ##5 rsp_valid_o);
  c_sv: cover property ($rose(hw_save_busy_n_oe_o));
  c_cmd: cover property (rsp_valid_o && rsp_untrusted_o);
endmodule
bind nvhc_host nvhc_host_chk nvhc_host_chk_i (.mclk_i, .rst_n_i, .req_valid_i, .req_op_i,
  .req_ready_o, .rsp_valid_o, .rsp_untrusted_o, .mem_ce_n_o, .mem_we_n_o, .mem_oe_n_o,
  .hw_save_busy_n_oe_o);

// ===== testbench/nvhc_dev.sv
module nvhc_dev (
  input wire [14:0] addr_i,
  input wire [7:0] hdq_i,
  input wire hdq_oe_i,
  input wire ce_n_i,
  input wire we_n_i,
  input wire oe_n_i,
  input wire hsb_oe_i,
  input wire supply_ok_i,
  output wire [7:0] dq_o,
  output wire hsb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:32767];
  logic [7:0] last = 8'h00;
  logic busy = 1'b0;
  logic hold = 1'b0;
  logic wr = 1'b0;
  logic wsel = 1'b0;
  wire lock = hold || !supply_ok_i;
  wire drv = !ce_n_i && we_n_i && !oe_n_i && !wsel && !busy && supply_ok_i;
  assign dq_o = hdq_oe_i ? hdq_i : drv ? mem[addr_i] : ~last;
  assign hsb_o = !(hsb_oe_i || busy);
  always @(negedge drv) last = mem[addr_i];
  always @(negedge ce_n_i) wsel = !we_n_i;
  always @(posedge we_n_i) if (!ce_n_i && !lock) begin
    mem[addr_i] = hdq_i;
    wr = 1'b1;
  end
  always @(posedge supply_ok_i) begin
    busy = 1'b1;
    hold = 1'b1;
    #1000 busy = 1'b0;
    hold = 1'b0;
  end
  always @(posedge hsb_oe_i) if (wr && !busy) begin
    busy = 1'b1;
    #25 hold = 1'b1;
    #275 busy = 1'b0;
    hold = 1'b0;
    wr = 1'b0;
  end
endmodule

// ===== testbench/nvhc_host_tb.sv
module nvhc_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sup = 1'b0;
  logic vld = 1'b0;
  logic [1:0] op = 2'h0;
  logic [14:0] adr = 15'h0000;
  logic [7:0] wd = 8'h00;
  logic cs = 1'b0;
  logic ls = 1'b0;
  logic cu = 1'b0;
  logic en = 1'b1;
  wire rdy, rv, ru, doe, ce, we, oe, hoe, hw_save_busy_n, bsy, hbo;
  wire [7:0] rd, hq, dq;
  wire [14:0] ma;
  int err_count = 0;
  int checks = 0;
  int w;
  always #4 mclk_i = ~mclk_i;
  nvhc_host #(.SS_CYC(32'd20), .RTCP_CYC(32'd40), .HREC_CYC(32'd20)) nvhc_host_i (.mclk_i,
    .rst_n_i, .en_i(en), .req_valid_i(vld), .req_op_i(op), .req_addr_i(adr),
    .req_wdata_i(wd), .req_cmd_step_i(cs), .req_last_step_i(ls), .req_clk_upd_i(cu),
    .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_rdata_o(rd), .rsp_untrusted_o(ru),
    .mem_addr_o(ma), .mem_dq_o(hq), .mem_dq_oe_o(doe), .mem_dq_i(dq), .mem_ce_n_o(ce),
    .mem_we_n_o(we), .mem_oe_n_o(oe), .hw_save_busy_n_o(hbo), .hw_save_busy_n_oe_o(hoe),
    .hw_save_busy_n_i(hw_save_busy_n), .supply_ok_i(sup), .busy_o(bsy));
  nvhc_dev nvhc_dev_i (.addr_i(ma), .hdq_i(hq), .hdq_oe_i(doe), .ce_n_i(ce), .we_n_i(we),
    .oe_n_i(oe), .hsb_oe_i(hoe && !hbo), .supply_ok_i(sup), .dq_o(dq), .hsb_o(hw_save_busy_n));
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rq(input logic [1:0] o, input logic [14:0] a, input logic [7:0] d,
    input logic c, input logic l);
    @(negedge mclk_i);
    {op, adr, wd, cs, ls, vld} = {o, a, d, c, l, 1'b1};
    while (rdy !== 1'b1) @(negedge mclk_i);
    @(negedge mclk_i);
    vld = 1'b0;
    for (w = 1; w < 9 && o < 2 && rv !== 1'b1; w++) @(negedge mclk_i);
    if (o < 2) chk(rv, 1'b1, "rsp");
    for (w = 1; o > 1 && rdy !== 1'b1; w++) @(negedge mclk_i);
  endtask
  task automatic t_rw();
    rq(1, 15'h7FFF, 8'hAA, 0, 0);
    rq(1, 15'h0000, 8'h55, 0, 0);
    rq(0, 15'h7FFF, 8'h00, 0, 0);
    chk(rd, 8'hAA, "rd hi");
    rq(0, 15'h0000, 8'h00, 0, 0);
    chk(rd, 8'h55, "rd lo");
  endtask
  task automatic t_save();
    rq(2, 0, 0, 0, 0);
    chk(w > 30, 1, "save held");
    rq(2, 0, 0, 0, 0);
    chk(w < 20, 1, "save skip");
    rq(0, 15'h7FFF, 8'h00, 0, 0);
    chk(rd, 8'hAA, "after save");
  endtask
  task automatic t_cmd();
    for (int i = 0; i < 6; i++) begin
      rq(0, 15'(i), 8'h00, 1, i == 5);
      chk(ru, i == 5, "untrusted");
    end
    rq(3, 0, 0, 0, 0);
    chk(w > 19 && w < 30, 1, "cmd wait");
    cu = 1'b1;
    rq(3, 0, 0, 0, 0);
    chk(w > 39 && w < 50, 1, "clk wait");
  endtask
  task automatic t_hold();
    @(negedge mclk_i);
    en = 1'b0;
    {op, adr, vld} = {2'h0, 15'h7FFF, 1'b1};
    repeat (3) @(negedge mclk_i);
    chk(ce, 1'b1, "frozen");
    {en, vld} = 2'b10;
    rq(0, 15'h7FFF, 8'h00, 0, 0);
    chk(rd, 8'hAA, "thawed");
  endtask
  task automatic t_pwr();
    @(negedge mclk_i);
    sup = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(bsy, 1'b1, "supply low");
    sup = 1'b1;
    for (w = 0; rdy !== 1'b1; w++) @(negedge mclk_i);
    chk(w > 100, 1, "restore held");
    rq(0, 15'h7FFF, 8'h00, 0, 0);
    chk(rd, 8'hAA, "restored");
  endtask
  task automatic results();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge mclk_i);
    rst_n_i = 1'b1;
    sup = 1'b1;
    t_rw();
    t_save();
    t_hold();
    t_pwr();
    t_cmd();
    results();
  end
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule
